/* logic/ccd_defines.svh */
`ifndef CCD_DEFINES_SVH
`define CCD_DEFINES_SVH

// oscillator source codes held in the configuration byte
`define CCD_OSC_W 2
`define CCD_OSC_XTAL 2'h0
`define CCD_OSC_RC 2'h1
`define CCD_OSC_EXT 2'h2
// field positions inside user_config_byte1
`define CCD_CFG_OSC_LSB 0
`define CCD_CFG_CLASSIC_BIT 7
// field position of clock_out_enable in port2_mode_reg1
`define CCD_PORT2_MODE_REG1_CLKEN_BIT 6
// reset values
`define CCD_DIV_RESET 8'h00
`define CCD_PORT2_MODE_REG1_RESET 8'h00
// clock output divides the cpu clock by six: three cpu clocks per phase
`define CCD_CLKOUT_HALF 3'h3
// nominal on-chip rc oscillator rate in mhz
`define CCD_RC_NOMINAL_MHZ 6

`endif

/* logic/ccd_pkg.sv */
package ccd_pkg;
	typedef logic [7:0] ccd_byte_t;
	typedef enum logic [1:0] {
		ccd_osc_xtal,
		ccd_osc_rc,
		ccd_osc_ext
	} ccd_osc_e;
endpackage

/* logic/ccd_clkout_gen.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ccd_defines.svh"
module ccd_clkout_gen
	import ccd_pkg::*;
(
	input wire logic mclk,
	input wire logic nrst,
	input wire logic ce,
	input wire logic cpu_tick,
	input wire logic enable,
	output logic clk_out
);
	typedef struct packed {
		logic [2:0] cnt;
		logic level;
	} ccd_co_s;
	ccd_co_s st_reg;
	ccd_co_s st_next;

	// *****************************
	// divide cpu clock ticks by six
	// *****************************
	always_comb begin
		st_next = st_reg;
		if (!enable) begin
			st_next.cnt = 3'h0;
			st_next.level = 1'b0;
		end else if (cpu_tick) begin
			if (st_reg.cnt == `CCD_CLKOUT_HALF - 3'h1) begin
				st_next.cnt = 3'h0;
				st_next.level = ~st_reg.level;
			end else begin
				st_next.cnt = st_reg.cnt + 3'h1;
			end
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			st_reg <= '0;
		end else if (ce) begin
			st_reg <= st_next;
		end
	end

	assign clk_out = st_reg.level;
endmodule
`default_nettype wire

/* logic/ccd_clock_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ccd_defines.svh"
module ccd_clock_ctrl
	import ccd_pkg::*;
(
	input wire logic mclk,
	input wire logic nrst,
	input wire logic ce,
	input wire logic osc_tick,
	input wire logic [7:0] user_config_byte1,
	input wire logic [7:0] port2_mode_reg1,
	input wire logic [7:0] cpu_clock_divider,
	input wire logic idle_mode,
	input wire logic port_out_data,
	input wire logic port_out_oe_n,
	input wire logic osc_out_port_pin_in,
	output logic cpu_tick,
	output logic periph_tick,
	output logic machine_cycle_tick,
	output logic cpu_run,
	output logic clock_out_pin_out,
	output logic clock_out_pin_oe_n,
	output logic osc_out_port_pin_sync,
	output logic clock_out_active,
	output logic classic_timing_select,
	output logic [1:0] osc_source
);
	typedef struct packed {
		logic cfg_loaded;
		ccd_osc_e osc;
		logic classic;
		logic half;
		ccd_byte_t div_cur;
		logic [8:0] div_cnt;
		logic [2:0] mc_cnt;
		logic cpu_tick;
		logic mc_tick;
		logic pin_out;
		logic pin_oe_n;
		logic clkout_en;
		logic pin_s1;
		logic pin_s2;
	} ccd_cc_s;
	ccd_cc_s st_reg;
	ccd_cc_s st_next;
	logic gen_clk;
	logic [1:0] cfg_osc;

	assign cfg_osc = user_config_byte1[`CCD_CFG_OSC_LSB +: `CCD_OSC_W];

	// *****************************
	// clock output divider
	// *****************************
	ccd_clkout_gen u_clkout (
		.mclk(mclk),
		.nrst(nrst),
		.ce(ce),
		.cpu_tick(st_reg.cpu_tick),
		.enable(st_reg.clkout_en),
		.clk_out(gen_clk)
	);

	// *****************************
	// next state
	// *****************************
	always_comb begin
		logic pre_tick;
		logic [8:0] limit;
		pre_tick = 1'b0;
		limit = 9'h000;
		st_next = st_reg;
		st_next.cpu_tick = 1'b0;
		st_next.mc_tick = 1'b0;
		// configuration is captured once after reset release and then held
		if (!st_reg.cfg_loaded) begin
			st_next.cfg_loaded = 1'b1;
			unique case (cfg_osc)
				`CCD_OSC_RC: st_next.osc = ccd_osc_rc;
				`CCD_OSC_EXT: st_next.osc = ccd_osc_ext;
				default: st_next.osc = ccd_osc_xtal;
			endcase
			st_next.classic = user_config_byte1[`CCD_CFG_CLASSIC_BIT];
		end
		// any oscillator source, rc included, feeds the same chain
		if (st_reg.cfg_loaded && osc_tick) begin
			// classic timing halves the oscillator ahead of the divider
			if (st_reg.classic) begin
				st_next.half = ~st_reg.half;
				pre_tick = st_reg.half;
			end else begin
				pre_tick = 1'b1;
			end
		end
		if (pre_tick) begin
			if (st_reg.div_cur == 8'h00) begin
				limit = 9'h000;
			end else begin
				limit = {st_reg.div_cur, 1'b1};
			end
			if (st_reg.div_cnt >= limit) begin
				st_next.div_cnt = 9'h000;
				st_next.cpu_tick = 1'b1;
				// latch new divisor only at period end; cpu never stalls
				st_next.div_cur = cpu_clock_divider;
			end else begin
				st_next.div_cnt = st_reg.div_cnt + 9'h001;
			end
		end
		if (st_next.cpu_tick) begin
			if (st_reg.mc_cnt == 3'h5) begin
				st_next.mc_cnt = 3'h0;
				st_next.mc_tick = 1'b1;
			end else begin
				st_next.mc_cnt = st_reg.mc_cnt + 3'h1;
			end
		end
		// idle does not gate the output; it tracks the oscillator source and the clock_out_enable bit only
		st_next.clkout_en = st_reg.cfg_loaded && (st_reg.osc != ccd_osc_xtal)
			&& port2_mode_reg1[`CCD_PORT2_MODE_REG1_CLKEN_BIT];
		if (st_reg.clkout_en) begin
			st_next.pin_out = gen_clk;
			st_next.pin_oe_n = 1'b0;
		end else if (st_reg.cfg_loaded && st_reg.osc == ccd_osc_ext) begin
			st_next.pin_out = port_out_data;
			st_next.pin_oe_n = port_out_oe_n;
		end else begin
			st_next.pin_out = 1'b0;
			st_next.pin_oe_n = 1'b1;
		end
		st_next.pin_s1 = osc_out_port_pin_in;
		st_next.pin_s2 = st_reg.pin_s1;
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			st_reg <= '{cfg_loaded: 1'b0, osc: ccd_osc_xtal, classic: 1'b0, half: 1'b0,
				div_cur: `CCD_DIV_RESET, div_cnt: 9'h000, mc_cnt: 3'h0, cpu_tick: 1'b0,
				mc_tick: 1'b0, pin_out: 1'b0, pin_oe_n: 1'b1, clkout_en: 1'b0,
				pin_s1: 1'b0, pin_s2: 1'b0};
		end else if (ce) begin
			st_reg <= st_next;
		end
	end

	assign cpu_tick = st_reg.cpu_tick;
	assign periph_tick = st_reg.cpu_tick;
	assign machine_cycle_tick = st_reg.mc_tick;
	assign cpu_run = st_reg.cfg_loaded;
	assign clock_out_pin_out = st_reg.pin_out;
	assign clock_out_pin_oe_n = st_reg.pin_oe_n;
	assign osc_out_port_pin_sync = st_reg.pin_s2;
	assign clock_out_active = st_reg.clkout_en;
	assign classic_timing_select = st_reg.classic;
	assign osc_source = st_reg.osc;
	// idle_mode is informational; the output deliberately ignores it
	logic unused_idle;
	assign unused_idle = idle_mode;
endmodule
`default_nettype wire

/* tb/ccd_chk.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ccd_defines.svh"
module ccd_chk(
	input wire logic mclk,
	input wire logic nrst,
	input wire logic ce,
	input wire logic osc_tick,
	input wire logic [7:0] port2_mode_reg1,
	input wire logic port_out_oe_n,
	input wire logic cpu_tick,
	input wire logic periph_tick,
	input wire logic cpu_run,
	input wire logic clock_out_pin_oe_n,
	input wire logic clock_out_active,
	input wire logic classic_timing_select,
	input wire logic [1:0] osc_source
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!nrst);
	AST_PERIPH: assert property (periph_tick == cpu_tick) else $error("periph tick differs");
	AST_TICK: assert property (cpu_tick |-> $past(osc_tick) && cpu_run) else $error("tick uncaused");
	AST_GAP: assert property (cpu_tick && classic_timing_select |=> !cpu_tick) else $error("classic gap");
	AST_CFG: assert property ($past(cpu_run) |-> $stable(osc_source) && $stable(classic_timing_select))
		else $error("config moved");
	AST_XTAL: assert property (osc_source != `CCD_OSC_RC && osc_source != `CCD_OSC_EXT |-> clock_out_pin_oe_n)
		else $error("xtal drives pin");
	AST_EN_ON: assert property (port2_mode_reg1[`CCD_PORT2_MODE_REG1_CLKEN_BIT] && osc_source == `CCD_OSC_RC && ce
		|=> clock_out_active) else $error("no enable");
	AST_EN_OFF: assert property (!clock_out_active && !$past(clock_out_active) && osc_source == `CCD_OSC_RC
		|-> clock_out_pin_oe_n) else $error("pin driven");
	AST_PORT: assert property (osc_source == `CCD_OSC_EXT && $past(osc_source) == `CCD_OSC_EXT && !clock_out_active
		&& !$past(clock_out_active) && $stable(port_out_oe_n) |-> clock_out_pin_oe_n == port_out_oe_n)
		else $error("port pin");
endmodule
`default_nettype wire

/* tb/ccd_sync_dev.sv */
`timescale 1ns/1ps
`default_nettype none
module ccd_sync_dev(
	input wire logic mclk,
	input wire logic pin,
	input wire logic drv_n,
	output int per
);
	int c = 1;
	logic q = 0;
	// period between rising edges seen while the pin is driven
	always @(posedge mclk) begin
		q <= pin;
		c <= c + 1;
		if (!drv_n && pin && !q) begin
			per <= c;
			c <= 1;
		end
	end
endmodule
`default_nettype wire

/* tb/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ccd_defines.svh"
module testbench;
	import ccd_pkg::*;
	logic mclk = 0, nrst = 0, ce = 1, osc_tick = 1, idle_mode = 0;
	logic port_out_data = 0, port_out_oe_n = 1, osc_out_port_pin_in = 1;
	logic [7:0] user_config_byte1 = 0, port2_mode_reg1 = 0, cpu_clock_divider = 0;
	logic cpu_tick, periph_tick, machine_cycle_tick, cpu_run, clock_out_pin_out, clock_out_pin_oe_n;
	logic osc_out_port_pin_sync, clock_out_active, classic_timing_select;
	logic [1:0] osc_source;
	int errors = 0, n_compared = 0, cyc = 0, c1 = 1, c2 = 1, p1, p2, pc, mn, n, e;
	logic [15:0] rows [5] = '{16'h0100, 16'h8100, 16'h0201, 16'h8202, 16'h0000};
	ccd_clock_ctrl u_ccd_clock_ctrl(.*);
	ccd_sync_dev u_ccd_sync_dev(.mclk, .pin(clock_out_pin_out), .drv_n(clock_out_pin_oe_n), .per(pc));
	task chk(input string nm, input logic [15:0] ex, input logic [15:0] got);
		n_compared++;
		if (ex !== got) begin
			errors++;
			$display("CHECK FAILED %s exp %0h got %0h", nm, ex, got);
		end
	endtask
	task print_verdict;
		$display("compared %0d errors %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task go(input logic [15:0] r);
		nrst <= 0;
		user_config_byte1 <= r[15:8];
		cpu_clock_divider <= r[7:0];
		repeat (6) @(posedge mclk);
		chk("rst oe_n", 1, clock_out_pin_oe_n);
		chk("rst run", 0, cpu_run);
		nrst <= 1;
	endtask
	initial forever #12.5 mclk = ~mclk;
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			errors++;
			print_verdict;
		end
		c1 <= cpu_tick ? 1 : c1 + 1;
		c2 <= machine_cycle_tick ? 1 : c2 + 1;
		if (machine_cycle_tick) p2 <= c2;
		if (cpu_tick) begin
			p1 <= c1;
			if (c1 < mn) mn <= c1;
		end
	end
	initial begin
		port2_mode_reg1 <= 8'h40;
		foreach (rows[i]) begin
			idle_mode <= i[0];
			go(rows[i]);
			repeat (300) @(posedge mclk);
			n = rows[i][7:0];
			e = (n == 0 ? 1 : 2 * (n + 1)) * (rows[i][15] ? 2 : 1);
			chk("cpu period", e[15:0], p1[15:0]);
			chk("mc period", 16'(6 * e), p2[15:0]);
			chk("osc source", 16'(rows[i][9:8]), 16'(osc_source));
			chk("classic", 16'(rows[i][15]), 16'(classic_timing_select));
			chk("clkout active", 16'(rows[i][9:8] != 0), 16'(clock_out_active));
			if (rows[i][9:8] == 0) chk("xtal oe_n", 1, clock_out_pin_oe_n);
			else chk("clkout period", 16'(6 * e), pc[15:0]);
		end
		go(16'h0201);
		repeat (100) @(posedge mclk);
		mn <= 99;
		cpu_clock_divider <= 3;
		repeat (200) @(posedge mclk);
		chk("min period", 4, mn[15:0]);
		chk("new period", 8, p1[15:0]);
		chk("run", 1, cpu_run);
		port2_mode_reg1 <= 0;
		idle_mode <= 1;
		port_out_data <= 1;
		port_out_oe_n <= 0;
		repeat (5) @(posedge mclk);
		chk("port oe", 0, clock_out_pin_oe_n);
		chk("port data", 1, clock_out_pin_out);
		chk("pin sync", 1, osc_out_port_pin_sync);
		// a new configuration byte mid-run must not reach the captured copy
		user_config_byte1 <= 8'h81;
		repeat (5) @(posedge mclk);
		chk("osc held", 2, 16'(osc_source));
		chk("classic held", 0, 16'(classic_timing_select));
		// rc source with the enable bit clear leaves the pin undriven
		go(16'h0100);
		repeat (20) @(posedge mclk);
		chk("rc off oe_n", 1, clock_out_pin_oe_n);
		chk("rc off active", 0, clock_out_active);
		print_verdict;
	end
endmodule
bind ccd_clock_ctrl ccd_chk u_ccd_chk(.*);
`default_nettype wire
